// *** core/ifl_defines.vh ***
// Offsets, field positions and reset values of the input fault live status bank
`ifndef IFL_DEFINES_VH
`define IFL_DEFINES_VH

// ==========================================================================
// Paging
`define IFL_PAGE_SEL_ADDR       8'h00
`define IFL_PAGE_SEL_RESET      8'h00
`define IFL_STATUS_PAGE         8'h01

// ==========================================================================
// Register offsets in the status page
`define IFL_SUMMARY_ADDR        8'h2d
`define IFL_CH1_ADDR            8'h2e
`define IFL_CH2_ADDR            8'h2f

// ==========================================================================
// Reset values
`define IFL_SUMMARY_RESET       8'h00
`define IFL_CHAN_RESET          8'h00
`define IFL_READ_IDLE           8'h00

// ==========================================================================
// Summary register fields
`define IFL_SUM_CH1_BIT         7
`define IFL_SUM_CH2_BIT         6
`define IFL_SUM_CH3_BIT         5
`define IFL_SUM_CH4_BIT         4
`define IFL_SUM_CH5_BIT         3
`define IFL_SUM_CH6_BIT         2
`define IFL_SUM_VBAT_BIT        1
`define IFL_SUM_RSVD_BIT        0

// ==========================================================================
// Per-channel status fields
`define IFL_CH_OPEN_BIT         7
`define IFL_CH_PAIR_BIT         6
`define IFL_CH_PGND_BIT         5
`define IFL_CH_MGND_BIT         4
`define IFL_CH_PBIAS_BIT        3
`define IFL_CH_MBIAS_BIT        2
`define IFL_CH_PVBAT_BIT        1
`define IFL_CH_MVBAT_BIT        0

`endif

// *** core/ifl_chan_live.v ***
// One channel of live fault status: input synchroniser and status register
`timescale 1ns/1ps
`include "ifl_defines.vh"

module ifl_chan_live #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys,
    input  wire             resetn,
    input  wire [WIDTH-1:0] detectRaw,
    output reg  [WIDTH-1:0] status_q,
    output wire             anyFault
);

    // ======================================================================
    // Two-stage synchroniser, first stage feeds only the second
    reg [WIDTH-1:0] syncA_q;
    reg [WIDTH-1:0] syncB_q;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            syncA_q <= {WIDTH{1'b0}};
            syncB_q <= {WIDTH{1'b0}};
        end else begin
            syncA_q <= detectRaw;
            syncB_q <= syncA_q;
        end
    end

    // ======================================================================
    // Live status: follows the detector every cycle, never latched
    always @(posedge clk_sys) begin
        if (!resetn) begin
            status_q <= `IFL_CHAN_RESET;
        end else begin
            status_q <= syncB_q;
        end
    end

    assign anyFault = |status_q;

endmodule // ifl_chan_live

// *** core/ifl_status_bank.v ***
// Input fault live status bank: page select, channel status and summary registers
//
// Notes on behaviour
// - summary bits 7..4 are set while channels 1..4 have any live fault.
// - summary bits 3 and 2 report channels 5 and 6, six-channel variant only.
// - summary bit 1 flags any battery short while battery sits below bias.
// - channel bit 7 reports an open input.
// - channel bit 6 reports the positive and negative legs shorted together.
// - channel bit 5 reports the positive leg shorted to ground.
// - channel bit 4 reports the negative leg shorted to ground.
// - channel bit 3 reports the positive leg shorted to mic bias output.
// - channel bit 2 reports the negative leg shorted to mic bias output.
// - channel bit 1 reports the positive leg shorted to battery sense.
// - channel bit 0 reports the negative leg shorted to battery sense.
// - channel 1 status lives at page 1 offset 0x2e, reset zero.
// - channel 2 status lives at page 1 offset 0x2f, same layout.
// - channel bits show the present fault, not a latched record.
// - summary register lives at page 1 offset 0x2d, reset zero.
// - host selects page 1 through the page register before access.
`timescale 1ns/1ps
`include "ifl_defines.vh"

module ifl_status_bank #(
    parameter NUM_CHANNELS = 6,
    parameter ADDR_WIDTH   = 8,
    parameter DATA_WIDTH   = 8
) (
    input  wire                  clk_sys,
    input  wire                  resetn,
    // Control port, already deserialised by the I2C/SPI front end
    input  wire                  regWrite,
    input  wire                  regRead,
    input  wire [ADDR_WIDTH-1:0] regAddr,
    input  wire [DATA_WIDTH-1:0] regWdata,
    output reg  [DATA_WIDTH-1:0] regRdata_q,
    output reg                   regRvalid_q,
    output reg                   regWriteIgnored_q,
    output reg  [DATA_WIDTH-1:0] pageSel_q,
    // Diagnostic comparator levels, asynchronous to clk_sys
    input  wire                  firstChannelOpen,
    input  wire                  firstChannelPairShort,
    input  wire                  firstChannelPositiveLegGnd,
    input  wire                  firstChannelNegativeLegGnd,
    input  wire                  firstChannelPositiveLegBias,
    input  wire                  firstChannelNegativeLegBias,
    input  wire                  firstChannelPositiveLegVbat,
    input  wire                  firstChannelNegativeLegVbat,
    input  wire                  secondChannelOpen,
    input  wire                  secondChannelPairShort,
    input  wire                  secondChannelPositiveLegGnd,
    input  wire                  secondChannelNegativeLegGnd,
    input  wire                  secondChannelPositiveLegBias,
    input  wire                  secondChannelNegativeLegBias,
    input  wire                  secondChannelPositiveLegVbat,
    input  wire                  secondChannelNegativeLegVbat,
    input  wire [7:0]            thirdChannelDetect,
    input  wire [7:0]            fourthChannelDetect,
    input  wire [7:0]            fifthChannelDetect,
    input  wire [7:0]            sixthChannelDetect,
    input  wire                  vbatBelowBias,
    // Live register images for the rest of the device
    output reg  [7:0]            faultSummary_q,
    output reg  [7:0]            firstChannelStatus_q,
    output reg  [7:0]            secondChannelStatus_q,
    output reg                   anyFault_q
);

    // ======================================================================
    // Detector bundles in register bit order
    wire [7:0] chanOneRaw;
    wire [7:0] chanTwoRaw;

    assign chanOneRaw[`IFL_CH_OPEN_BIT]  = firstChannelOpen;
    assign chanOneRaw[`IFL_CH_PAIR_BIT]  = firstChannelPairShort;
    assign chanOneRaw[`IFL_CH_PGND_BIT]  = firstChannelPositiveLegGnd;
    assign chanOneRaw[`IFL_CH_MGND_BIT]  = firstChannelNegativeLegGnd;
    assign chanOneRaw[`IFL_CH_PBIAS_BIT] = firstChannelPositiveLegBias;
    assign chanOneRaw[`IFL_CH_MBIAS_BIT] = firstChannelNegativeLegBias;
    assign chanOneRaw[`IFL_CH_PVBAT_BIT] = firstChannelPositiveLegVbat;
    assign chanOneRaw[`IFL_CH_MVBAT_BIT] = firstChannelNegativeLegVbat;

    assign chanTwoRaw[`IFL_CH_OPEN_BIT]  = secondChannelOpen;
    assign chanTwoRaw[`IFL_CH_PAIR_BIT]  = secondChannelPairShort;
    assign chanTwoRaw[`IFL_CH_PGND_BIT]  = secondChannelPositiveLegGnd;
    assign chanTwoRaw[`IFL_CH_MGND_BIT]  = secondChannelNegativeLegGnd;
    assign chanTwoRaw[`IFL_CH_PBIAS_BIT] = secondChannelPositiveLegBias;
    assign chanTwoRaw[`IFL_CH_MBIAS_BIT] = secondChannelNegativeLegBias;
    assign chanTwoRaw[`IFL_CH_PVBAT_BIT] = secondChannelPositiveLegVbat;
    assign chanTwoRaw[`IFL_CH_MVBAT_BIT] = secondChannelNegativeLegVbat;

    wire [47:0] detectAll;

    assign detectAll = {sixthChannelDetect, fifthChannelDetect, fourthChannelDetect,
                        thirdChannelDetect, chanTwoRaw, chanOneRaw};

    // ======================================================================
    // Per-channel live status, one instance per channel
    wire [47:0] statusAll;
    wire [5:0]  chanAny;

    genvar ch;
    generate
        for (ch = 0; ch < 6; ch = ch + 1) begin : gChan
            ifl_chan_live #(
                .WIDTH     (8)
            ) uChan (
                .clk_sys   (clk_sys),
                .resetn    (resetn),
                .detectRaw (detectAll[ch*8 +: 8]),
                .status_q  (statusAll[ch*8 +: 8]),
                .anyFault  (chanAny[ch])
            );
        end
    endgenerate

    // ======================================================================
    // Battery level synchroniser
    reg vbatSyncA_q;
    reg vbatSyncB_q;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            vbatSyncA_q <= 1'b0;
            vbatSyncB_q <= 1'b0;
        end else begin
            vbatSyncA_q <= vbatBelowBias;
            vbatSyncB_q <= vbatSyncA_q;
        end
    end

    // ======================================================================
    // Summary composition
    // Four-channel parts report channels 5 and 6 as clean even if the pins float.
    wire       sixChan;
    wire [5:0] vbatShortPerChan;
    reg  [7:0] summary_d;

    assign sixChan = (NUM_CHANNELS >= 6);

    generate
        for (ch = 0; ch < 6; ch = ch + 1) begin : gVbat
            assign vbatShortPerChan[ch] = statusAll[ch*8 + `IFL_CH_PVBAT_BIT] |
                                          statusAll[ch*8 + `IFL_CH_MVBAT_BIT];
        end
    endgenerate

    always @* begin
        summary_d                    = `IFL_SUMMARY_RESET;
        summary_d[`IFL_SUM_CH1_BIT]  = chanAny[0];
        summary_d[`IFL_SUM_CH2_BIT]  = chanAny[1];
        summary_d[`IFL_SUM_CH3_BIT]  = chanAny[2];
        summary_d[`IFL_SUM_CH4_BIT]  = chanAny[3];
        summary_d[`IFL_SUM_CH5_BIT]  = sixChan & chanAny[4];
        summary_d[`IFL_SUM_CH6_BIT]  = sixChan & chanAny[5];
        // Channels 5 and 6 only count on the six-channel part
        summary_d[`IFL_SUM_VBAT_BIT] = vbatSyncB_q &
            (|vbatShortPerChan[3:0] | (sixChan & |vbatShortPerChan[5:4]));
        summary_d[`IFL_SUM_RSVD_BIT] = 1'b0;
    end

    // ======================================================================
    // Live register images
    always @(posedge clk_sys) begin
        if (!resetn) begin
            faultSummary_q        <= `IFL_SUMMARY_RESET;
            firstChannelStatus_q  <= `IFL_CHAN_RESET;
            secondChannelStatus_q <= `IFL_CHAN_RESET;
            anyFault_q            <= 1'b0;
        end else begin
            faultSummary_q        <= summary_d;
            firstChannelStatus_q  <= statusAll[7:0];
            secondChannelStatus_q <= statusAll[15:8];
            anyFault_q            <= |summary_d[7:1];
        end
    end

    // ======================================================================
    // Address decode
    wire inStatusPage;
    wire hitPage;
    wire hitSummary;
    wire hitChanOne;
    wire hitChanTwo;
    wire hitStatus;

    assign hitPage      = (regAddr == `IFL_PAGE_SEL_ADDR);
    assign inStatusPage = (pageSel_q == `IFL_STATUS_PAGE);
    assign hitSummary   = inStatusPage & (regAddr == `IFL_SUMMARY_ADDR);
    assign hitChanOne   = inStatusPage & (regAddr == `IFL_CH1_ADDR);
    assign hitChanTwo   = inStatusPage & (regAddr == `IFL_CH2_ADDR);
    assign hitStatus    = hitSummary | hitChanOne | hitChanTwo;

    // ======================================================================
    // Page select, present at offset 0 of every page
    always @(posedge clk_sys) begin
        if (!resetn) begin
            pageSel_q <= `IFL_PAGE_SEL_RESET;
        end else if (regWrite && hitPage) begin
            pageSel_q <= regWdata;
        end
    end

    // Writes to the read-only status registers are dropped, flagged for one cycle
    always @(posedge clk_sys) begin
        if (!resetn) begin
            regWriteIgnored_q <= 1'b0;
        end else begin
            regWriteIgnored_q <= regWrite & hitStatus;
        end
    end

    // ======================================================================
    // Read path
    // Reads sample the same flops that drive the image outputs, so read data
    // holds the image port value of the strobe cycle, one cycle later.
    reg [DATA_WIDTH-1:0] readMux;

    always @* begin
        readMux = `IFL_READ_IDLE;
        if (hitPage) begin
            readMux = pageSel_q;
        end else if (hitSummary) begin
            readMux = faultSummary_q;
        end else if (hitChanOne) begin
            readMux = firstChannelStatus_q;
        end else if (hitChanTwo) begin
            readMux = secondChannelStatus_q;
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            regRdata_q  <= `IFL_READ_IDLE;
            regRvalid_q <= 1'b0;
        end else begin
            regRvalid_q <= regRead;
            if (regRead) begin
                regRdata_q <= readMux;
            end
        end
    end

endmodule // ifl_status_bank

// *** tb/ifl_status_bank_props.sv ***
// Concurrent checks on the ports of the input fault live status bank
`timescale 1ns/1ps
module ifl_status_bank_props (
    input wire       clk_sys,
    input wire       resetn,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata_q,
    input wire       regRvalid_q,
    input wire       regWriteIgnored_q,
    input wire [7:0] pageSel_q,
    input wire       firstChannelOpen,
    input wire [7:0] faultSummary_q,
    input wire [7:0] firstChannelStatus_q,
    input wire [7:0] secondChannelStatus_q,
    input wire       anyFault_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ==========================================================================
    // Register port
    read_valid_a: assert property (regRead |=> regRvalid_q)
        else $error("read strobe not answered next cycle");
    no_read_valid_a: assert property (!regRead |=> !regRvalid_q)
        else $error("read valid without a read strobe");
    page_write_a: assert property (
        regWrite && regAddr == 8'h00 |=> pageSel_q == $past(regWdata))
        else $error("page select not updated by write");
    ch1_read_a: assert property (
        regRead && regAddr == 8'h2e && pageSel_q == 8'h01
        |=> regRdata_q == $past(firstChannelStatus_q))
        else $error("channel one read data wrong");
    sum_read_a: assert property (
        regRead && regAddr == 8'h2d && pageSel_q == 8'h01
        |=> regRdata_q == $past(faultSummary_q))
        else $error("summary read data wrong");
    wrong_page_a: assert property (
        regRead && regAddr == 8'h2e && pageSel_q != 8'h01
        |=> regRdata_q == 8'h00)
        else $error("status visible outside its page");
    write_ignored_a: assert property (
        regWrite && pageSel_q == 8'h01 && regAddr >= 8'h2d
        && regAddr <= 8'h2f |=> regWriteIgnored_q)
        else $error("status write not flagged as ignored");

    // ==========================================================================
    // Live status and summary
    sum_ch1_a: assert property (faultSummary_q[7] == (|firstChannelStatus_q))
        else $error("summary bit 7 disagrees with channel one");
    sum_ch2_a: assert property (faultSummary_q[6] == (|secondChannelStatus_q))
        else $error("summary bit 6 disagrees with channel two");
    sum_rsvd_a: assert property (faultSummary_q[0] == 1'b0)
        else $error("reserved summary bit set");
    open_seen_a: assert property (
        $rose(firstChannelOpen) |-> ##[1:5] firstChannelStatus_q[7])
        else $error("open input not reported in time");
    any_fault_a: assert property (anyFault_q == (|faultSummary_q[7:1]))
        else $error("any-fault flag disagrees with summary");
endmodule // ifl_status_bank_props

bind ifl_status_bank ifl_status_bank_props props_u (
    .clk_sys(clk_sys), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
    .regRvalid_q(regRvalid_q), .regWriteIgnored_q(regWriteIgnored_q),
    .pageSel_q(pageSel_q), .firstChannelOpen(firstChannelOpen),
    .faultSummary_q(faultSummary_q), .firstChannelStatus_q(firstChannelStatus_q),
    .secondChannelStatus_q(secondChannelStatus_q), .anyFault_q(anyFault_q));

// *** tb/ifl_status_bank_bench.sv ***
// Self-checking bench for the input fault live status bank
`timescale 1ns/1ps
module ifl_status_bank_bench;
    reg         clk_sys  = 1'b0;
    reg         resetn   = 1'b0;
    reg         regWrite = 1'b0;
    reg         regRead  = 1'b0;
    reg  [7:0]  regAddr  = 8'h00;
    reg  [7:0]  regWdata = 8'h00;
    reg  [7:0]  ch1      = 8'h00;
    reg  [7:0]  ch2      = 8'h00;
    reg  [31:0] chx      = 32'h0;
    reg         vbat     = 1'b0;
    wire [7:0]  regRdata_q;
    wire        regRvalid_q;
    wire        regWriteIgnored_q;
    wire [7:0]  pageSel_q;
    wire [7:0]  faultSummary_q;
    wire [7:0]  firstChannelStatus_q;
    wire [7:0]  secondChannelStatus_q;
    wire        anyFault_q;
    integer     miscompares = 0;
    integer     n_checks    = 0;
    integer     i;

    always #50 clk_sys = ~clk_sys;

    ifl_status_bank dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .regRvalid_q(regRvalid_q), .regWriteIgnored_q(regWriteIgnored_q),
        .pageSel_q(pageSel_q),
        .firstChannelOpen(ch1[7]), .firstChannelPairShort(ch1[6]),
        .firstChannelPositiveLegGnd(ch1[5]), .firstChannelNegativeLegGnd(ch1[4]),
        .firstChannelPositiveLegBias(ch1[3]), .firstChannelNegativeLegBias(ch1[2]),
        .firstChannelPositiveLegVbat(ch1[1]), .firstChannelNegativeLegVbat(ch1[0]),
        .secondChannelOpen(ch2[7]), .secondChannelPairShort(ch2[6]),
        .secondChannelPositiveLegGnd(ch2[5]), .secondChannelNegativeLegGnd(ch2[4]),
        .secondChannelPositiveLegBias(ch2[3]), .secondChannelNegativeLegBias(ch2[2]),
        .secondChannelPositiveLegVbat(ch2[1]), .secondChannelNegativeLegVbat(ch2[0]),
        .thirdChannelDetect(chx[7:0]), .fourthChannelDetect(chx[15:8]),
        .fifthChannelDetect(chx[23:16]), .sixthChannelDetect(chx[31:24]),
        .vbatBelowBias(vbat), .faultSummary_q(faultSummary_q),
        .firstChannelStatus_q(firstChannelStatus_q),
        .secondChannelStatus_q(secondChannelStatus_q), .anyFault_q(anyFault_q));

    // ==========================================================================
    // Shared helpers
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task rd(input [7:0] a, input [7:0] e);
        begin
            @(negedge clk_sys);
            regRead = 1'b1;
            regAddr = a;
            @(negedge clk_sys);
            regRead = 1'b0;
            chk({7'h0, regRvalid_q}, 8'h01);
            chk(regRdata_q, e);
        end
    endtask

    task wr(input [7:0] a, input [7:0] d, input ign);
        begin
            @(negedge clk_sys);
            regWrite = 1'b1;
            regAddr = a;
            regWdata = d;
            @(negedge clk_sys);
            regWrite = 1'b0;
            chk({7'h0, regWriteIgnored_q}, {7'h0, ign});
        end
    endtask

    // Comparator levels are asynchronous; six cycles cover the two-flop sync
    task setf(input [7:0] a, input [7:0] b, input [31:0] x, input v);
        begin
            @(negedge clk_sys);
            ch1 = a;
            ch2 = b;
            chx = x;
            vbat = v;
            repeat (6) @(negedge clk_sys);
        end
    endtask

    // ==========================================================================
    // Scenarios
    task t_access;
        begin
            chk(pageSel_q, 8'h00);
            wr(8'h00, 8'h01, 1'b0);
            chk(pageSel_q, 8'h01);
            rd(8'h00, 8'h01);
            rd(8'h2d, 8'h00);
            rd(8'h2e, 8'h00);
            rd(8'h2f, 8'h00);
            rd(8'h40, 8'h00);
        end
    endtask

    task t_channel;
        for (i = 0; i < 8; i = i + 1) begin
            setf(8'h01 << i, 8'h80 >> i, 32'h0, 1'b0);
            rd(8'h2e, 8'h01 << i);
            rd(8'h2f, 8'h80 >> i);
            rd(8'h2d, 8'hc0);
        end
    endtask

    task t_others;
        for (i = 0; i < 4; i = i + 1) begin
            setf(8'h00, 8'h00, 32'h1 << (8 * i), 1'b0);
            rd(8'h2d, 8'h20 >> i);
            chk({7'h0, anyFault_q}, 8'h01);
        end
    endtask

    task t_vbat;
        begin
            setf(8'h02, 8'h00, 32'h0, 1'b1);
            rd(8'h2d, 8'h82);
            setf(8'h00, 8'h01, 32'h0, 1'b1);
            rd(8'h2d, 8'h42);
            setf(8'h02, 8'h00, 32'h0, 1'b0);
            rd(8'h2d, 8'h80);
            setf(8'h08, 8'h00, 32'h0, 1'b1);
            rd(8'h2d, 8'h80);
            setf(8'h00, 8'h00, 32'h0200_0000, 1'b1);
            rd(8'h2d, 8'h06);
            setf(8'h00, 8'h00, 32'h0, 1'b1);
            rd(8'h2e, 8'h00);
            rd(8'h2d, 8'h00);
            chk({7'h0, anyFault_q}, 8'h00);
        end
    endtask

    task t_write;
        begin
            setf(8'h10, 8'h00, 32'h0, 1'b0);
            wr(8'h2e, 8'hff, 1'b1);
            rd(8'h2e, 8'h10);
            wr(8'h2d, 8'hff, 1'b1);
            rd(8'h2d, 8'h80);
            wr(8'h00, 8'h00, 1'b0);
            rd(8'h2e, 8'h00);
            wr(8'h00, 8'h01, 1'b0);
            rd(8'h2e, 8'h10);
        end
    endtask

    // Mid-run reset with faults standing; images must clear, then refill
    task t_reset;
        begin
            setf(8'hff, 8'h01, 32'h0, 1'b1);
            chk(firstChannelStatus_q, 8'hff);
            chk(secondChannelStatus_q, 8'h01);
            chk(faultSummary_q, 8'hc2);
            resetn = 1'b0;
            repeat (2) @(negedge clk_sys);
            chk(firstChannelStatus_q, 8'h00);
            chk(secondChannelStatus_q, 8'h00);
            chk(faultSummary_q, 8'h00);
            chk({7'h0, anyFault_q}, 8'h00);
            chk(regRdata_q, 8'h00);
            chk(pageSel_q, 8'h00);
            resetn = 1'b1;
            repeat (4) @(negedge clk_sys);
            rd(8'h2e, 8'h00);
            wr(8'h00, 8'h01, 1'b0);
            rd(8'h2e, 8'hff);
            rd(8'h2d, 8'hc2);
            chk({7'h0, anyFault_q}, 8'h01);
        end
    endtask

    // ==========================================================================
    // Verdict
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #(3000 * 100);
        miscompares = miscompares + 1;
        stop_test;
    end

    initial begin
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        t_access;
        t_channel;
        t_others;
        t_vbat;
        t_write;
        t_reset;
        stop_test;
    end
endmodule // ifl_status_bank_bench
